// file: rtl/dca_params.svh
// Purpose: Constants of the channel arbiter and flag block
// Assumes: Included by the package and the top module
// Notes: Offsets are byte addresses on the register bus
`ifndef DCA_PARAMS_SVH
`define DCA_PARAMS_SVH
// Bus address width and carrier channel id width
`define DCA_AW 12
`define DCA_CHW 4
// Flag register index, byte address is four times it
`define DCA_IDX_FLAGS 10'h04E
`define DCA_OFS_FLAGS {`DCA_IDX_FLAGS, 2'b00}
// Further registers
`define DCA_OFS_SEL 12'h100
`define DCA_OFS_CTRL 12'h104
`define DCA_OFS_IENCLR 12'h108
`define DCA_OFS_IENSET 12'h10C
`define DCA_OFS_PEND 12'h110
`define DCA_OFS_BUSY 12'h114
`define DCA_OFS_LVEX 12'h118
`define DCA_OFS_IRQST 12'h11C
`define DCA_OFS_IRQMSK 12'h120
`define DCA_OFS_ACTIVE 12'h124
// Control fields of the selected channel
`define DCA_CTL_EN 0
`define DCA_CTL_SUSPEND_FLAG 1
`define DCA_CTL_LVL 2
// Flag fields
`define DCA_FLG_TRANSFER_ERROR_FLAG 0
`define DCA_FLG_TRANSFER_COMPLETE_FLAG 1
`define DCA_FLG_SUSPEND_FLAG 2
// Reset values
`define DCA_RST_FLAGS 3'h0
`define DCA_RST_IEN 3'h0
`define DCA_RST_LVL 2'h0
// Bus answers
`define DCA_RESP_OK 2'h0
`define DCA_RESP_ERR 2'h2
`endif

// file: rtl/dca_pkg.sv
// Purpose: Types of the channel arbiter and flag block
// Assumes: dca_params.svh on the include path
// Notes: Carriers for grant and burst completion
`include "dca_params.svh"
package dca_pkg;
   // What a channel does after its granted bursts
   typedef enum logic [1:0] {
      DCA_ACT_REQUEUE,
      DCA_ACT_WAIT,
      DCA_ACT_SUSPEND,
      DCA_ACT_DISABLE
   } dca_act_e;
   // Burst completion report from the transfer engine
   typedef struct packed {
      logic valid;
      logic [`DCA_CHW-1:0] ch;
      dca_act_e act;
   } dca_done_s;
   // Grant toward the transfer engine
   typedef struct packed {
      logic valid;
      logic [`DCA_CHW-1:0] ch;
   } dca_grant_s;
endpackage

// file: rtl/dca_arbiter.sv
// Purpose: Channel arbiter, busy/pending tracking, channel flags
// Assumes: CH from 2 to 16, AXI4-Lite register access
// Notes: Registers use byte lane 0 only, except IRQST and IRQMSK, which take their data from the full word
`timescale 1ns/1ps
`default_nettype none
`include "dca_params.svh"

module dca_arbiter #(
   parameter int CH = 4,
   parameter int LV = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`DCA_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`DCA_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [CH-1:0] trig,
   input wire logic [CH-1:0] suspend_flag_ev,
   input wire logic [CH-1:0] bus_err,
   input wire logic [CH-1:0] inv_desc,
   input wire logic [CH-1:0] blk_done,
   input wire logic [CH-1:0] blk_int,
   input wire logic [CH-1:0] blk_suspend_flag,
   input wire dca_pkg::dca_done_s done,
   output dca_pkg::dca_grant_s grant,
   output logic [CH-1:0] chan_irq,
   output logic irq
);
   import dca_pkg::*;

   localparam int SW = $clog2(CH);

   // Write channel holding registers
   logic aw_full_reg;
   logic w_full_reg;
   logic [`DCA_AW-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   // Read channel registers
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // Channel state, one bit or field per channel
   logic [CH-1:0] en_reg;
   logic [CH-1:0] suspend_flag_reg;
   logic [CH-1:0] pend_reg;
   logic [CH-1:0] busy_reg;
   logic [CH-1:0][1:0] lvl_reg;
   logic [CH-1:0][2:0] flag_reg;
   logic [CH-1:0][2:0] ien_reg;
   logic [CH-1:0] chirq_reg;
   // Global interrupt status and mask
   logic [CH-1:0] gst_reg;
   logic [CH-1:0] gmsk_reg;
   logic irq_reg;
   // Selector, arbiter and level state
   logic [SW-1:0] sel_reg;
   logic active_reg;
   logic [SW-1:0] act_ch_reg;
   logic [LV-1:0] lvex_reg;
   dca_grant_s grant_reg;

   // Handshakes
   wire aw_hs = awvalid & awready_reg;
   wire w_hs = wvalid & wready_reg;
   wire ar_hs = arvalid & arready_reg;

   // A write runs once address and data are both held
   wire wr_do = aw_full_reg & w_full_reg & ~bvalid_reg;
   wire wr_lane = wr_do & wstrb_reg[0];
   wire [7:0] wb = wdata_reg[7:0];

   // Write decode
   wire wa_sel = awaddr_reg == `DCA_OFS_SEL;
   wire wa_ctrl = awaddr_reg == `DCA_OFS_CTRL;
   wire wa_flags = awaddr_reg == `DCA_OFS_FLAGS;
   wire wa_iclr = awaddr_reg == `DCA_OFS_IENCLR;
   wire wa_iset = awaddr_reg == `DCA_OFS_IENSET;
   wire wa_gst = awaddr_reg == `DCA_OFS_IRQST;
   wire wa_gmsk = awaddr_reg == `DCA_OFS_IRQMSK;
   wire wa_ro = (awaddr_reg == `DCA_OFS_PEND) | (awaddr_reg == `DCA_OFS_BUSY) |
      (awaddr_reg == `DCA_OFS_LVEX) | (awaddr_reg == `DCA_OFS_ACTIVE);
   wire wa_hit = wa_sel | wa_ctrl | wa_flags | wa_iclr | wa_iset | wa_gst | wa_gmsk | wa_ro;

   // Write strobes
   wire wr_sel = wr_lane & wa_sel;
   wire wr_ctrl = wr_lane & wa_ctrl;
   wire wr_flags = wr_lane & wa_flags;
   wire wr_iclr = wr_lane & wa_iclr;
   wire wr_iset = wr_lane & wa_iset;
   wire wr_gst = wr_lane & wa_gst;
   wire wr_gmsk = wr_lane & wa_gmsk;

   // Read decode
   wire ra_sel = araddr == `DCA_OFS_SEL;
   wire ra_ctrl = araddr == `DCA_OFS_CTRL;
   wire ra_flags = araddr == `DCA_OFS_FLAGS;
   wire ra_ien = (araddr == `DCA_OFS_IENCLR) | (araddr == `DCA_OFS_IENSET);
   wire ra_pend = araddr == `DCA_OFS_PEND;
   wire ra_busy = araddr == `DCA_OFS_BUSY;
   wire ra_lvex = araddr == `DCA_OFS_LVEX;
   wire ra_gst = araddr == `DCA_OFS_IRQST;
   wire ra_gmsk = araddr == `DCA_OFS_IRQMSK;
   wire ra_act = araddr == `DCA_OFS_ACTIVE;
   wire ra_hit = ra_sel | ra_ctrl | ra_flags | ra_ien | ra_pend | ra_busy | ra_lvex |
      ra_gst | ra_gmsk | ra_act;

   // Selected channel views
   wire [3:0] sel_ctrl = {lvl_reg[sel_reg], suspend_flag_reg[sel_reg], en_reg[sel_reg]};
   wire [31:0] zpad = 32'h0;

   // Read data mux
   wire [31:0] rd_mux =
      ra_sel ? {zpad[31:SW], sel_reg} :
      ra_ctrl ? {28'h0, sel_ctrl} :
      ra_flags ? {29'h0, flag_reg[sel_reg]} :
      ra_ien ? {29'h0, ien_reg[sel_reg]} :
      ra_pend ? {zpad[31:CH], pend_reg} :
      ra_busy ? {zpad[31:CH], busy_reg} :
      ra_lvex ? {zpad[31:LV], lvex_reg} :
      ra_gst ? {zpad[31:CH], gst_reg} :
      ra_gmsk ? {zpad[31:CH], gmsk_reg} :
      ra_act ? {zpad[31:SW+1], active_reg, act_ch_reg} : 32'h0;

   // Queue membership and arbitration
   wire [CH-1:0] queued = pend_reg & en_reg & ~suspend_flag_reg;
   logic pick_ok;
   logic [SW-1:0] pick;
   logic [1:0] pick_lvl;

   // Highest level wins, lowest index among equals
   always_comb begin
      pick_ok = 1'b0;
      pick = '0;
      pick_lvl = 2'h0;
      for (int i = CH - 1; i >= 0; i--) begin
         if (queued[i] && (!pick_ok || lvl_reg[i] >= pick_lvl)) begin
            pick_ok = 1'b1;
            pick = SW'(i);
            pick_lvl = lvl_reg[i];
         end
      end
   end

   // Grant only while no channel is active
   wire grant_fire = pick_ok & ~active_reg;
   // Completion of the active channel's bursts
   wire done_act = done.valid & active_reg & (done.ch == `DCA_CHW'(act_ch_reg));

   // Level executing view
   logic [LV-1:0] lvex_next;
   always_comb begin
      lvex_next = '0;
      for (int i = 0; i < CH; i++) begin
         if (pend_reg[i] | busy_reg[i]) begin
            lvex_next[lvl_reg[i]] = 1'b1;
         end
      end
   end

   // Per-channel logic
   genvar g;
   generate
      for (g = 0; g < CH; g++) begin : g_ch
         // This channel selected by the selector
         wire me = sel_reg == SW'(g);
         wire grant_me = grant_fire & (pick == SW'(g));
         wire done_me = done_act & (act_ch_reg == SW'(g));
         wire d_wait = done_me & (done.act == DCA_ACT_WAIT);
         wire d_suspend_flag = done_me & (done.act == DCA_ACT_SUSPEND);
         wire d_dis = done_me & (done.act == DCA_ACT_DISABLE);
         wire d_req = done_me & (done.act == DCA_ACT_REQUEUE);
         wire wctl = wr_ctrl & me;
         // Software suspend command: writing one while not suspended
         wire sw_suspend_flag = wctl & wb[`DCA_CTL_SUSPEND_FLAG] & ~suspend_flag_reg[g];
         // Suspend causes
         wire suspend_flag_set = sw_suspend_flag | suspend_flag_ev[g] | inv_desc[g] | d_suspend_flag |
            (blk_done[g] & blk_suspend_flag[g]);
         // Enable: software write, or disable at burst end
         wire en_next = wctl ? wb[`DCA_CTL_EN] : (d_dis ? 1'b0 : en_reg[g]);
         wire suspend_flag_next = suspend_flag_set | (suspend_flag_reg[g] & ~(wctl & ~wb[`DCA_CTL_SUSPEND_FLAG]));
         // Request into the queue
         wire req = trig[g] & en_reg[g] & ~suspend_flag_reg[g];
         wire pend_next = en_next & (req | d_req | (pend_reg[g] & ~grant_me));
         wire busy_next = en_next & (grant_me | (busy_reg[g] & ~(d_wait | d_suspend_flag)));
         // Flag events and software clears
         wire [2:0] fset = {suspend_flag_set, blk_done[g] & blk_int[g], bus_err[g] | inv_desc[g]};
         wire [2:0] fclr = (wr_flags & me) ? wb[2:0] : 3'h0;
         wire [2:0] flag_next = fset | (flag_reg[g] & ~fclr);
         wire [2:0] iset = (wr_iset & me) ? wb[2:0] : 3'h0;
         wire [2:0] iclr = (wr_iclr & me) ? wb[2:0] : 3'h0;
         wire [2:0] ien_next = iset | (ien_reg[g] & ~iclr);

         // Channel registers
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               en_reg[g] <= 1'b0;
               suspend_flag_reg[g] <= 1'b0;
               pend_reg[g] <= 1'b0;
               busy_reg[g] <= 1'b0;
               lvl_reg[g] <= `DCA_RST_LVL;
               flag_reg[g] <= `DCA_RST_FLAGS;
               ien_reg[g] <= `DCA_RST_IEN;
               chirq_reg[g] <= 1'b0;
            end else begin
               en_reg[g] <= en_next;
               suspend_flag_reg[g] <= suspend_flag_next;
               pend_reg[g] <= pend_next;
               busy_reg[g] <= busy_next;
               lvl_reg[g] <= wctl ? wb[`DCA_CTL_LVL+:2] : lvl_reg[g];
               flag_reg[g] <= flag_next;
               ien_reg[g] <= ien_next;
               chirq_reg[g] <= |(flag_next & ien_next);
            end
         end
      end
   endgenerate

   // Global status: channel requests set, write one clears
   // Full data word, so channels above eight stay reachable
   wire [CH-1:0] gclr = wr_gst ? wdata_reg[CH-1:0] : '0;
   wire [CH-1:0] gst_next = chirq_reg | (gst_reg & ~gclr);
   wire [CH-1:0] gmsk_next = wr_gmsk ? wdata_reg[CH-1:0] : gmsk_reg;

   // Arbiter, selector and interrupt registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_reg <= '0;
         active_reg <= 1'b0;
         act_ch_reg <= '0;
         lvex_reg <= '0;
         gst_reg <= '0;
         gmsk_reg <= '0;
         irq_reg <= 1'b0;
         grant_reg <= '0;
      end else begin
         sel_reg <= wr_sel ? wb[SW-1:0] : sel_reg;
         // Active channel held until its completion report
         if (grant_fire) begin
            active_reg <= 1'b1;
            act_ch_reg <= pick;
         end else if (done_act) begin
            active_reg <= 1'b0;
         end
         grant_reg.valid <= grant_fire | (active_reg & ~done_act);
         grant_reg.ch <= grant_fire ? `DCA_CHW'(pick) : grant_reg.ch;
         lvex_reg <= lvex_next;
         gst_reg <= gst_next;
         gmsk_reg <= gmsk_next;
         irq_reg <= |(gst_next & gmsk_next);
      end
   end

   // Write address and data capture, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
      end else begin
         aw_full_reg <= wr_do ? 1'b0 : (aw_full_reg | aw_hs);
         w_full_reg <= wr_do ? 1'b0 : (w_full_reg | w_hs);
         awaddr_reg <= aw_hs ? awaddr : awaddr_reg;
         wdata_reg <= w_hs ? wdata : wdata_reg;
         wstrb_reg <= w_hs ? wstrb : wstrb_reg;
         awready_reg <= ~(aw_hs | (aw_full_reg & ~wr_do));
         wready_reg <= ~(w_hs | (w_full_reg & ~wr_do));
      end
   end

   // Write response after both halves are taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `DCA_RESP_OK;
      end else if (wr_do) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wa_hit ? `DCA_RESP_OK : `DCA_RESP_ERR;
      end else if (bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Read answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= `DCA_RESP_OK;
      end else begin
         arready_reg <= ~(ar_hs | (rvalid_reg & ~rready));
         if (ar_hs) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= ra_hit ? `DCA_RESP_OK : `DCA_RESP_ERR;
         end else if (rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // Outputs straight from flops
   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   assign grant = grant_reg;
   assign chan_irq = chirq_reg;
   assign irq = irq_reg;

endmodule // dca_arbiter
`default_nettype wire

// file: dv/dca_monitor.sv
// Purpose: Bus and grant checks on the arbiter ports
// Assumes: Bound onto dca_arbiter, one clock domain
// Notes: Sees a subset of the top ports only
`timescale 1ns/1ps
`default_nettype none
module dca_monitor #(
   parameter int CH = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awready,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   input wire dca_pkg::dca_done_s done,
   input wire dca_pkg::dca_grant_s grant
);
   import dca_pkg::*;
   // All checks on the one clock, quiet in reset
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Write answer stands until taken
   chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   // Read answer one cycle after address
   chk_r_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   // Read data stands until taken
   chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data moved");
   // No new read while answer outstanding
   chk_ar_block: assert property (rvalid |-> !arready)
      else $error("read taken while busy");
   // Write channels reopen as the answer rises
   chk_w_reopen: assert property ($rose(bvalid) |-> awready && wready)
      else $error("write channels not reopened");
   // Grant holds its channel until the burst ends
   chk_grant_hold: assert property (grant.valid && !done.valid |=> grant.valid && $stable(grant.ch))
      else $error("grant moved mid burst");
   // Grant drops one cycle after its completion
   chk_grant_end: assert property (done.valid && grant.valid && done.ch == grant.ch |=> !grant.valid)
      else $error("grant outlived completion");
   // Granted channel exists
   chk_grant_range: assert property (grant.valid |-> grant.ch < CH)
      else $error("grant to missing channel");
endmodule // dca_monitor
`default_nettype wire

// file: dv/dca_engine_model.sv
// Purpose: Transfer engine that answers grants
// Assumes: One completion per grant
// Notes: Latency and action set by the bench
`timescale 1ns/1ps
`default_nettype none
module dca_engine_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire dca_pkg::dca_grant_s grant,
   input wire dca_pkg::dca_act_e act,
   input wire logic [7:0] lat,
   output var dca_pkg::dca_done_s done
);
   import dca_pkg::*;
   logic [7:0] cnt_reg; // Cycles spent on this grant
   // Count the burst, then report it once
   always_ff @(posedge aclk) begin
      done.valid <= 1'b0;
      done.ch <= ~done.ch; // Idle id toggles every cycle outside reset
      if (!aresetn) begin
         cnt_reg <= 8'h00;
         done.ch <= 4'h0;
      end else if (done.valid) begin
         cnt_reg <= 8'h00;
      end else if (grant.valid) begin
         if (cnt_reg == lat) begin
            done <= '{1'b1, grant.ch, act};
         end else begin
            cnt_reg <= cnt_reg + 8'h01;
         end
      end
   end
endmodule // dca_engine_model
`default_nettype wire

// file: dv/tb_dca_arbiter.sv
// Purpose: Self-checking bench of the arbiter
// Assumes: Four channels, fixed seed
// Notes: Flags are exercised on channel 3
`timescale 1ns/1ps
`default_nettype none
`include "dca_params.svh"
module tb_dca_arbiter;
   import dca_pkg::*;
   localparam int CH = 4;
   localparam logic [5:0] EV [6] = '{6'h20, 6'h10, 6'h08, 6'h06, 6'h04, 6'h05};
   localparam logic [31:0] EF [6] = '{32'h5, 32'h1, 32'h4, 32'h2, 32'h0, 32'h4};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [`DCA_AW-1:0] awaddr = '0;
   logic [`DCA_AW-1:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [CH-1:0] trig = '0, suspend_flag_ev = '0, bus_err = '0, inv_desc = '0;
   logic [CH-1:0] blk_done = '0, blk_int = '0, blk_suspend_flag = '0, chan_irq;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   dca_done_s done;
   dca_grant_s grant;
   dca_act_e act = DCA_ACT_WAIT;
   logic [7:0] lat = 8'h28;
   logic [1:0] lvl [CH];
   logic [31:0] seed = 32'hB9821609;
   int n_fail = 0;
   int checks_done = 0;
   always #20 aclk = ~aclk;
   dca_arbiter #(.CH(CH), .LV(4)) u_dca_arbiter (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .trig(trig), .suspend_flag_ev(suspend_flag_ev),
      .bus_err(bus_err), .inv_desc(inv_desc), .blk_done(blk_done), .blk_int(blk_int), .blk_suspend_flag(blk_suspend_flag),
      .done(done), .grant(grant), .chan_irq(chan_irq), .irq(irq));
   dca_engine_model u_dca_engine_model (.aclk(aclk), .aresetn(aresetn), .grant(grant), .act(act),
      .lat(lat), .done(done));
   // Verdict and end of run
   task automatic stop_test();
      if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait ran out
   task automatic hang(input int k);
      if (k >= 200) begin
         n_fail++;
         $display("[ERR] %0t wait ran out", $time);
         stop_test();
      end
   endtask
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Highest level, lowest index among pending
   function automatic logic [3:0] pick(input logic [CH-1:0] p);
      int b;
      b = -1;
      for (int i = 0; i < CH; i++) if (p[i] && (b < 0 || lvl[i] > lvl[b])) b = i;
      return 4'(b);
   endfunction
   // Level bits of busy or pending channels
   function automatic logic [31:0] lvex(input logic [CH-1:0] p);
      lvex = '0;
      for (int i = 0; i < CH; i++) if (p[i]) lvex[lvl[i]] = 1'b1;
   endfunction
   // Register write, both channels offered together
   task automatic wr(input logic [`DCA_AW-1:0] a, input logic [31:0] d);
      int k;
      int s;
      s = int'(rnd() & 32'h3); // Random answer stall
      @(posedge aclk);
      {awaddr, wdata} <= {a, d};
      {awvalid, wvalid} <= 2'h3;
      bready <= (s == 0);
      k = 0;
      do begin
         @(posedge aclk);
         k++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (k >= s && !bready) bready <= 1'b1;
      end while (!(bvalid && bready) && k < 200);
      hang(k);
      bready <= 1'b0;
      chk({30'h0, bresp}, `DCA_RESP_OK);
   endtask
   // Register read with expected word and answer
   task automatic rd(input logic [`DCA_AW-1:0] a, input logic [31:0] e, input logic [1:0] r);
      int k;
      int s;
      s = int'(rnd() & 32'h3); // Random answer stall
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= (s == 0);
      k = 0;
      do begin
         @(posedge aclk);
         k++;
         if (arready) arvalid <= 1'b0;
         if (k >= s && !rready) rready <= 1'b1;
      end while (!(rvalid && rready) && k < 200);
      hang(k);
      rready <= 1'b0;
      chk(rdata, e);
      chk({30'h0, r}, {30'h0, rresp});
   endtask
   // Wait for a grant and check its channel
   task automatic wgrant(input logic [3:0] g);
      int k;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
      end while (grant.valid !== 1'b1 && k < 200);
      hang(k);
      chk({28'h0, grant.ch}, {28'h0, g});
   endtask
   task automatic widle();
      int k;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
      end while (grant.valid !== 1'b0 && k < 200);
      hang(k);
   endtask
   // One-cycle event pulse on channel 3
   task automatic ev(input logic [5:0] m);
      @(posedge aclk);
      {inv_desc[3], bus_err[3], suspend_flag_ev[3], blk_done[3], blk_int[3], blk_suspend_flag[3]} <= m;
      @(posedge aclk);
      {inv_desc[3], bus_err[3], suspend_flag_ev[3], blk_done[3], blk_int[3], blk_suspend_flag[3]} <= 6'h00;
   endtask
   task automatic pulse(input logic [CH-1:0] t);
      @(posedge aclk);
      trig <= t;
      @(posedge aclk);
      trig <= '0;
   endtask
   // Main sequence
   initial begin
      logic [31:0] r;
      logic [3:0] g;
      logic [CH-1:0] rem;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`DCA_OFS_FLAGS, 32'h0, `DCA_RESP_OK);
      rd(12'hFFC, 32'h0, `DCA_RESP_ERR);
      // Random levels, channel 3 copies channel 1, every channel enabled
      for (int i = 0; i < CH; i++) begin
         r = rnd();
         lvl[i] = (i == 3) ? lvl[1] : r[1:0];
         wr(`DCA_OFS_SEL, i);
         wr(`DCA_OFS_CTRL, {28'h0, lvl[i], 2'b01});
      end
      pulse('1);
      rem = '1;
      repeat (CH) begin
         g = pick(rem);
         wgrant(g);
         rd(`DCA_OFS_PEND, {28'h0, rem & ~(4'h1 << g)}, `DCA_RESP_OK);
         rd(`DCA_OFS_BUSY, {28'h0, 4'h1 << g}, `DCA_RESP_OK);
         rd(`DCA_OFS_ACTIVE, {29'h0, 1'b1, g[1:0]}, `DCA_RESP_OK);
         rd(`DCA_OFS_LVEX, lvex(rem), `DCA_RESP_OK);
         rem[g] = 1'b0;
         widle();
      end
      rd(`DCA_OFS_BUSY, 32'h0, `DCA_RESP_OK);
      // Prompt requeue keeps busy
      r = rnd();
      lat <= {6'h00, r[1:0]};
      act <= DCA_ACT_REQUEUE;
      pulse(4'h1);
      wgrant(4'h0);
      repeat (3) rd(`DCA_OFS_BUSY, 32'h1, `DCA_RESP_OK);
      act <= DCA_ACT_WAIT;
      repeat (20) @(posedge aclk);
      rd(`DCA_OFS_BUSY, 32'h0, `DCA_RESP_OK);
      // Suspend and disable while pending
      lat <= 8'h3C;
      pulse(4'h1);
      wgrant(4'h0);
      pulse(4'h2);
      wr(`DCA_OFS_SEL, 32'h1);
      wr(`DCA_OFS_CTRL, {28'h0, lvl[1], 2'b11});
      rd(`DCA_OFS_PEND, 32'h2, `DCA_RESP_OK);
      rd(`DCA_OFS_FLAGS, 32'h4, `DCA_RESP_OK);
      widle();
      repeat (5) @(posedge aclk);
      chk({31'h0, grant.valid}, 32'h0);
      wr(`DCA_OFS_CTRL, {28'h0, lvl[1], 2'b01});
      wgrant(4'h1);
      pulse(4'h4);
      wr(`DCA_OFS_SEL, 32'h2);
      wr(`DCA_OFS_CTRL, 32'h0);
      rd(`DCA_OFS_PEND, 32'h0, `DCA_RESP_OK);
      widle();
      // Flag causes and clearing on channel 3
      wr(`DCA_OFS_SEL, 32'h3);
      for (int i = 0; i < 6; i++) begin
         ev(EV[i]);
         rd(`DCA_OFS_FLAGS, EF[i], `DCA_RESP_OK);
         wr(`DCA_OFS_FLAGS, 32'h0);
         rd(`DCA_OFS_FLAGS, EF[i], `DCA_RESP_OK);
         wr(`DCA_OFS_FLAGS, 32'h7);
         rd(`DCA_OFS_FLAGS, 32'h0, `DCA_RESP_OK);
      end
      // Interrupt raise, mask, clear
      ev(6'h10);
      wr(`DCA_OFS_IENSET, 32'h1);
      rd(`DCA_OFS_IENSET, 32'h1, `DCA_RESP_OK);
      chk({28'h0, chan_irq}, 32'h8);
      wr(`DCA_OFS_IRQMSK, 32'h8);
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, 32'h1);
      wr(`DCA_OFS_IENCLR, 32'h1);
      chk({28'h0, chan_irq}, 32'h0);
      wr(`DCA_OFS_IENSET, 32'h1);
      // Error pulse lands on the edge the clear executes
      fork
         wr(`DCA_OFS_FLAGS, 32'h1);
         begin
            repeat (2) @(posedge aclk);
            bus_err[3] <= 1'b1;
            @(posedge aclk);
            bus_err[3] <= 1'b0;
         end
      join
      rd(`DCA_OFS_FLAGS, 32'h1, `DCA_RESP_OK);
      wr(`DCA_OFS_FLAGS, 32'h1);
      chk({28'h0, chan_irq}, 32'h0);
      wr(`DCA_OFS_IRQST, 32'h8);
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      stop_test();
   end
endmodule // tb_dca_arbiter
bind dca_arbiter dca_monitor #(.CH(CH)) u_dca_monitor (.aclk(aclk), .aresetn(aresetn), .awready(awready),
   .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
   .rdata(rdata), .rvalid(rvalid), .rready(rready), .done(done), .grant(grant));
`default_nettype wire
